// >>> core/tisc_top.sv
`timescale 1ns/1ns

// Function
// - Byte after threshold command is threshold plus 32; legal zero to ninety.
// - Threshold zero, sent as space, turns the filter off; zero after reset.
// - Met when either axis reaches threshold from last report; that report recentres.
// - Edge mode: enable seeds centre; press/release report, coordinates refresh only when met.
// - Polled mode: each trigger reports; repeat last unless met, then fresh.
// - Streaming: report only when met, paced by the report rate.
// - Gated streaming: press and release report; flow at rate once met while held.
// - Reset and reset command set both axes to 200 lines per inch.
// - Restricted configurations clamp coordinates to 4095.
// - Preset bytes U d c f g h i pick 25..508 lpi on both axes.
// - Scale command 0x72 then X low, X high, Y low, Y high totals.
// - X and Y resolutions are independent, each 10 to 508 lpi.
// - Total divided by axis length is truncated to whole lpi.
// - Zero total for an axis leaves that axis unchanged.
module tisc_top (
   input  wire logic                  CLK,
   input  wire logic                  RESET_N,
   input  wire logic [7:0]            RX_DATA,
   input  wire logic                  RX_VALID,
   input  wire tisc_pkg::tisc_point_t POS,
   input  wire logic                  POS_VALID,
   input  wire logic                  BUTTON,
   input  wire tisc_pkg::tisc_mode_t  MODE,
   input  wire logic                  TRIGGER,
   input  wire logic                  RATE_TICK,
   input  wire logic                  RESTRICTED,
   output      tisc_pkg::tisc_report_t REPORT,
   output      logic                  REPORT_VALID,
   input  wire logic                  REPORT_READY,
   output      logic [6:0]            THRESHOLD,
   output      logic                  FILTER_ON,
   output      logic                  MET,
   output      logic [8:0]            RES_X,
   output      logic [8:0]            RES_Y
);
   import tisc_pkg::*;

   typedef struct packed {
      tisc_parse_t        parse;
      logic [THR_W-1:0]   thresh;
      logic [RES_W-1:0]   res_x;
      logic [RES_W-1:0]   res_y;
      logic [7:0]         x_lo;
      logic [TOT_W-1:0]   x_tot;
      logic [7:0]         y_lo;
      tisc_point_t        cur;
      tisc_point_t        center;
      tisc_point_t        last;
      logic               btn_prev;
      logic               trig_pend;
      logic               met;
   } tisc_state_t;

   tisc_state_t  s;
   tisc_state_t  next_s;
   logic         met;
   logic         edge_seen;
   logic         issue;
   logic         fresh;
   logic         in_ready;
   logic [7:0]   thr_arg;
   tisc_report_t push_data;

   // ---------------------------------------------------------------
   // Filter and scheduling decisions
   // ---------------------------------------------------------------
   // Square test around the last issued report; filter off always met
   assign met = (s.thresh == THR_RESET)
              || reach(s.cur.x, s.center.x, s.thresh)
              || reach(s.cur.y, s.center.y, s.thresh);
   assign edge_seen = (BUTTON != s.btn_prev);
   assign thr_arg   = RX_DATA - THR_OFFSET;

   // Per report mode: whether to issue and whether coordinates refresh
   always_comb begin
      issue = 1'b0;
      fresh = 1'b0;
      case (MODE)
         MODE_EDGE: begin
            issue = edge_seen;
            fresh = met;
         end
         MODE_POLL: begin
            issue = s.trig_pend;
            fresh = met;
         end
         MODE_STREAM: begin
            issue = RATE_TICK && met;
            fresh = 1'b1;
         end
         MODE_GATED: begin
            issue = edge_seen || (BUTTON && s.btn_prev && RATE_TICK && met);
            fresh = met;
         end
         default: begin
            issue = 1'b0;
            fresh = 1'b0;
         end
      endcase
   end

   // Report content: fresh coordinates or the last issued ones
   always_comb begin
      push_data.pos    = fresh ? s.cur : s.last;
      push_data.button = BUTTON;
   end

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb begin
      next_s     = s;
      next_s.met = met;

      // Latest scanned position, clamped when restricted
      if (POS_VALID) begin
         next_s.cur.x = limit_coord(POS.x, RESTRICTED);
         next_s.cur.y = limit_coord(POS.y, RESTRICTED);
      end

      // Issue only when the buffer can take it; edges wait otherwise
      if (in_ready) begin
         next_s.btn_prev = BUTTON;
         if (issue) begin
            next_s.trig_pend = 1'b0;
            if (fresh) begin
               next_s.center = s.cur;
               next_s.last   = s.cur;
            end
         end
      end
      if (TRIGGER) begin
         next_s.trig_pend = 1'b1;                                // Set wins
      end

      // Command parser
      if (RX_VALID) begin
         case (s.parse)
            PS_CMD: begin
               case (RX_DATA)
                  CMD_RESET: begin
                     next_s.thresh = THR_RESET;
                     next_s.res_x  = RES_RESET;
                     next_s.res_y  = RES_RESET;
                  end
                  CMD_THRESH: next_s.parse = PS_THRESH;
                  CMD_SCALE:  next_s.parse = PS_XLO;
                  CMD_R25: begin
                     next_s.res_x = RES_25;
                     next_s.res_y = RES_25;
                  end
                  CMD_R100: begin
                     next_s.res_x = RES_100;
                     next_s.res_y = RES_100;
                  end
                  CMD_R200: begin
                     next_s.res_x = RES_200;
                     next_s.res_y = RES_200;
                  end
                  CMD_R254: begin
                     next_s.res_x = RES_254;
                     next_s.res_y = RES_254;
                  end
                  CMD_R400: begin
                     next_s.res_x = RES_400;
                     next_s.res_y = RES_400;
                  end
                  CMD_R500: begin
                     next_s.res_x = RES_500;
                     next_s.res_y = RES_500;
                  end
                  CMD_R508: begin
                     next_s.res_x = RES_508;
                     next_s.res_y = RES_508;
                  end
                  default: next_s.parse = PS_CMD;
               endcase
            end
            PS_THRESH: begin
               // Out of range operands are dropped
               if (RX_DATA >= THR_OFFSET && thr_arg <= THR_MAX) begin
                  next_s.thresh = thr_arg[THR_W-1:0];
                  if (s.thresh == THR_RESET) begin
                     next_s.center = s.cur;
                  end
               end
               next_s.parse = PS_CMD;
            end
            PS_XLO: begin
               next_s.x_lo  = RX_DATA;
               next_s.parse = PS_XHI;
            end
            PS_XHI: begin
               next_s.x_tot = {RX_DATA[4:0], s.x_lo};
               next_s.parse = PS_YLO;
            end
            PS_YLO: begin
               next_s.y_lo  = RX_DATA;
               next_s.parse = PS_YHI;
            end
            PS_YHI: begin
               next_s.res_x = scale_res(s.x_tot, s.res_x);
               next_s.res_y = scale_res({RX_DATA[4:0], s.y_lo}, s.res_y);
               next_s.parse = PS_CMD;
            end
            default: next_s.parse = PS_CMD;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // State register
   // ---------------------------------------------------------------
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         s        <= '0;
         s.parse  <= PS_CMD;
         s.thresh <= THR_RESET;
         s.res_x  <= RES_RESET;
         s.res_y  <= RES_RESET;
         s.met    <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   // ---------------------------------------------------------------
   // Report buffer
   // ---------------------------------------------------------------
   tisc_buf #(
      .W ($bits(tisc_report_t))
   ) u_buf (
      .CLK       (CLK),
      .RESET_N   (RESET_N),
      .IN_VALID  (issue),
      .IN_READY  (in_ready),
      .IN_DATA   (push_data),
      .OUT_VALID (REPORT_VALID),
      .OUT_READY (REPORT_READY),
      .OUT_DATA  (REPORT)
   );

   // Status outputs
   assign THRESHOLD = s.thresh;
   assign FILTER_ON = (s.thresh != THR_RESET);
   assign MET       = s.met;
   assign RES_X     = s.res_x;
   assign RES_Y     = s.res_y;

endmodule

// >>> core/tisc_pkg.sv
package tisc_pkg;

   // ---------------------------------------------------------------
   // Widths
   // ---------------------------------------------------------------
   localparam int COORD_W = 16;
   localparam int RES_W   = 9;
   localparam int THR_W   = 7;
   localparam int TOT_W   = 13;

   // ---------------------------------------------------------------
   // Command bytes
   // ---------------------------------------------------------------
   localparam logic [7:0] CMD_RESET  = 8'h00;
   localparam logic [7:0] CMD_THRESH = 8'h49;
   localparam logic [7:0] CMD_SCALE  = 8'h72;
   localparam logic [7:0] CMD_R25    = 8'h55;
   localparam logic [7:0] CMD_R100   = 8'h64;
   localparam logic [7:0] CMD_R200   = 8'h63;
   localparam logic [7:0] CMD_R254   = 8'h66;
   localparam logic [7:0] CMD_R400   = 8'h67;
   localparam logic [7:0] CMD_R500   = 8'h68;
   localparam logic [7:0] CMD_R508   = 8'h69;

   // ---------------------------------------------------------------
   // Threshold operand encoding
   // ---------------------------------------------------------------
   localparam logic [7:0]       THR_OFFSET = 8'h20;
   localparam logic [7:0]       THR_MAX    = 8'h5a;
   localparam logic [THR_W-1:0] THR_RESET  = 7'h00;

   // ---------------------------------------------------------------
   // Resolutions in lines per inch
   // ---------------------------------------------------------------
   localparam logic [RES_W-1:0] RES_25    = 9'h019;
   localparam logic [RES_W-1:0] RES_100   = 9'h064;
   localparam logic [RES_W-1:0] RES_200   = 9'h0c8;
   localparam logic [RES_W-1:0] RES_254   = 9'h0fe;
   localparam logic [RES_W-1:0] RES_400   = 9'h190;
   localparam logic [RES_W-1:0] RES_500   = 9'h1f4;
   localparam logic [RES_W-1:0] RES_508   = 9'h1fc;
   localparam logic [RES_W-1:0] RES_MIN   = 9'h00a;
   localparam logic [RES_W-1:0] RES_RESET = RES_200;
   localparam logic [TOT_W-1:0] AXIS_INCH = 13'h000c;

   // Coordinate ceiling of the restricted configurations
   localparam logic [COORD_W-1:0] COORD_LIMIT = 16'h0fff;

   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      PS_CMD    = 3'b000,
      PS_THRESH = 3'b001,
      PS_XLO    = 3'b010,
      PS_XHI    = 3'b011,
      PS_YLO    = 3'b100,
      PS_YHI    = 3'b101
   } tisc_parse_t;

   typedef enum logic [1:0] {
      MODE_EDGE   = 2'b00,
      MODE_POLL   = 2'b01,
      MODE_STREAM = 2'b10,
      MODE_GATED  = 2'b11
   } tisc_mode_t;

   typedef struct packed {
      logic [COORD_W-1:0] x;
      logic [COORD_W-1:0] y;
   } tisc_point_t;

   typedef struct packed {
      tisc_point_t pos;
      logic        button;
   } tisc_report_t;

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   // Clamp a coordinate in the restricted configurations
   function automatic logic [COORD_W-1:0] limit_coord(input logic [COORD_W-1:0] v,
                                                      input logic               restr);
      return (restr && v > COORD_LIMIT) ? COORD_LIMIT : v;
   endfunction

   // Distance on one axis reaches the threshold
   function automatic logic reach(input logic [COORD_W-1:0] a,
                                  input logic [COORD_W-1:0] b,
                                  input logic [THR_W-1:0]   t);
      logic [COORD_W-1:0] d;
      d = (a > b) ? (a - b) : (b - a);
      return d >= {9'h000, t};
   endfunction

   // Axis total count to whole lines per inch; zero keeps the old value
   function automatic logic [RES_W-1:0] scale_res(input logic [TOT_W-1:0] total,
                                                  input logic [RES_W-1:0] old);
      logic [TOT_W-1:0] q;
      q = total / AXIS_INCH;
      if (total == 13'h0000) return old;
      if (q < {4'h0, RES_MIN}) return RES_MIN;
      if (q > {4'h0, RES_508}) return RES_508;
      return q[RES_W-1:0];
   endfunction

endpackage

// >>> core/tisc_buf.sv
`timescale 1ns/1ns

// Two-entry buffer between the report scheduler and the report sender
module tisc_buf #(
   parameter int W = 8
) (
   input  wire logic         CLK,
   input  wire logic         RESET_N,
   input  wire logic         IN_VALID,
   output      logic         IN_READY,
   input  wire logic [W-1:0] IN_DATA,
   output      logic         OUT_VALID,
   input  wire logic         OUT_READY,
   output      logic [W-1:0] OUT_DATA
);

   typedef struct packed {
      logic [1:0][W-1:0] mem;
      logic              wr;
      logic              rd;
      logic [1:0]        count;
   } tisc_buf_state_t;

   tisc_buf_state_t s;
   tisc_buf_state_t next_s;
   logic            push;
   logic            pop;

   // ---------------------------------------------------------------
   // Handshakes
   // ---------------------------------------------------------------
   assign IN_READY  = (s.count != 2'h2);
   assign OUT_VALID = (s.count != 2'h0);
   assign OUT_DATA  = s.mem[s.rd];
   assign push      = IN_VALID && IN_READY;
   assign pop       = OUT_VALID && OUT_READY;

   // Next-state of the ring
   always_comb begin
      next_s = s;
      if (push) begin
         next_s.mem[s.wr] = IN_DATA;
         next_s.wr        = ~s.wr;
      end
      if (pop) begin
         next_s.rd = ~s.rd;
      end
      if (push && !pop) begin
         next_s.count = s.count + 2'h1;
      end else if (pop && !push) begin
         next_s.count = s.count - 2'h1;
      end
   end

   // State register
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

endmodule

// >>> tb/tisc_sva.sv
`timescale 1ns/1ns

// ------------------------------------------------------------
// Port checker for the command block
// ------------------------------------------------------------
module tisc_sva (
   input wire logic                   CLK,
   input wire logic                   RESET_N,
   input wire logic [7:0]             RX_DATA,
   input wire logic                   RX_VALID,
   input wire tisc_pkg::tisc_report_t REPORT,
   input wire logic                   REPORT_VALID,
   input wire logic                   REPORT_READY,
   input wire logic [6:0]             THRESHOLD,
   input wire logic                   FILTER_ON,
   input wire logic                   MET,
   input wire logic [8:0]             RES_X,
   input wire logic [8:0]             RES_Y
);
   import tisc_pkg::*;
   logic [2:0] ops;
   logic       thr_op;
   logic       cmd;
   logic       thr_opnd;
   logic       ok_thr;

   // Byte classes seen on the receive side
   assign cmd      = RX_VALID && (ops == 3'h0);
   assign thr_opnd = RX_VALID && thr_op && (ops == 3'h1);
   assign ok_thr   = RX_DATA inside {[THR_OFFSET:8'h7a]};

   // Preset byte to resolution, zero when not a preset
   function automatic logic [8:0] preset(input logic [7:0] b);
      case (b)
         CMD_R25: return RES_25;
         CMD_R100: return RES_100;
         CMD_R200: return RES_200;
         CMD_R254: return RES_254;
         CMD_R400: return RES_400;
         CMD_R500: return RES_500;
         CMD_R508: return RES_508;
         default: return 9'h000;
      endcase
   endfunction

   // Operand bytes still owed to the open command
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         ops    <= 3'h0;
         thr_op <= 1'b0;
      end else if (RX_VALID && ops != 3'h0) begin
         ops <= ops - 3'h1;
      end else if (cmd && (RX_DATA == CMD_THRESH || RX_DATA == CMD_SCALE)) begin
         ops    <= (RX_DATA == CMD_THRESH) ? 3'h1 : 3'h4;
         thr_op <= (RX_DATA == CMD_THRESH);
      end
   end

   default clocking dc @(posedge CLK); endclocking
   default disable iff (!RESET_N);

   a_filter_flag: assert property (FILTER_ON == (THRESHOLD != 7'h00))
      else $error("filter flag disagrees with threshold");
   a_thresh_load: assert property (thr_opnd && ok_thr
         |=> THRESHOLD == 7'($past(RX_DATA) - THR_OFFSET))
      else $error("threshold operand not loaded");
   a_thresh_ignore: assert property (thr_opnd && !ok_thr |=> $stable(THRESHOLD))
      else $error("bad threshold operand changed threshold");
   a_preset_both: assert property (cmd && preset(RX_DATA) != 9'h000
         |=> RES_X == preset($past(RX_DATA)) && RES_Y == preset($past(RX_DATA)))
      else $error("preset resolution not applied");
   a_reset_cmd: assert property (cmd && RX_DATA == CMD_RESET
         |=> THRESHOLD == THR_RESET && RES_X == RES_RESET && RES_Y == RES_RESET)
      else $error("reset command defaults wrong");
   a_operand_quiet: assert property (RX_VALID && ops > 3'h1
         |=> $stable(RES_X) && $stable(RES_Y) && $stable(THRESHOLD))
      else $error("scale operand acted as a command");
   a_report_hold: assert property (REPORT_VALID && !REPORT_READY
         |=> REPORT_VALID && $stable(REPORT))
      else $error("stalled report lost or changed");
   a_met_open: assert property (THRESHOLD == 7'h00 |=> MET)
      else $error("met low with filter off");
   a_res_span: assert property (RES_X inside {[RES_MIN:RES_508]}
         && RES_Y inside {[RES_MIN:RES_508]})
      else $error("resolution out of span");

   c_thresh: cover property (thr_opnd && ok_thr);
   c_scale: cover property (RX_VALID && !thr_op && ops == 3'h1);
   c_stall: cover property (REPORT_VALID && !REPORT_READY);
endmodule

bind tisc_top tisc_sva i_tisc_sva (
   .CLK(CLK), .RESET_N(RESET_N), .RX_DATA(RX_DATA), .RX_VALID(RX_VALID),
   .REPORT(REPORT), .REPORT_VALID(REPORT_VALID), .REPORT_READY(REPORT_READY),
   .THRESHOLD(THRESHOLD), .FILTER_ON(FILTER_ON), .MET(MET), .RES_X(RES_X), .RES_Y(RES_Y));

// >>> tb/tisc_host.sv
`timescale 1ns/1ns

// ------------------------------------------------------------
// Host side: sends command bytes one per pulse
// ------------------------------------------------------------
module tisc_host #(
   parameter int GAP = 50000
) (
   input  wire logic       clk,
   output      logic [7:0] rx_data,
   output      logic       rx_valid
);
   import tisc_pkg::*;

   initial begin
      rx_valid = 1'b0;
      rx_data  = 8'h00;
   end

   // One byte for one edge; idle line shows the inverse
   task automatic send(input logic [7:0] b);
      @(posedge clk);
      #1;
      rx_data  = b;
      rx_valid = 1'b1;
      @(posedge clk);
      #1;
      rx_valid = 1'b0;
      rx_data  = ~b;
   endtask

   // Threshold command with offset added
   task automatic send_thr(input logic [6:0] t);
      send(CMD_THRESH);
      send({1'b0, t} + THR_OFFSET);
   endtask

   // Scale sequence, then the quiet gap
   task automatic send_scale(input logic [12:0] xt, input logic [12:0] yt);
      send(CMD_SCALE);
      send(xt[7:0]);
      send((xt[12:8] > 5'h17) ? 8'h17 : {3'h0, xt[12:8]});
      send(yt[7:0]);
      send((yt[12:8] > 5'h17) ? 8'h17 : {3'h0, yt[12:8]});
      repeat (GAP) @(posedge clk);
   endtask
endmodule

// >>> tb/tisc_tb_top.sv
`timescale 1ns/1ns

module tisc_tb_top;
   import tisc_pkg::*;
   logic         clk          = 1'b0;
   logic         reset_n      = 1'b0;
   logic [7:0]   rx_data;
   logic         rx_valid;
   tisc_point_t  pos;
   logic         pos_valid;
   logic         button;
   tisc_mode_t   mode;
   logic         trigger;
   logic         rate_tick;
   logic         restricted;
   tisc_report_t report;
   logic         report_valid;
   logic         report_ready;
   logic [6:0]   threshold;
   logic         filter_on;
   logic         met;
   logic [8:0]   res_x;
   logic [8:0]   res_y;
   int           fails        = 0;
   int           num_checks   = 0;
   logic [7:0]   pcmd [7]     = '{CMD_R25, CMD_R100, CMD_R200, CMD_R254, CMD_R400, CMD_R500,
                                  CMD_R508};
   logic [8:0]   pres [7]     = '{RES_25, RES_100, RES_200, RES_254, RES_400, RES_500, RES_508};
   logic [12:0]  sx [4]       = '{13'h0324, 13'h0000, 13'h17ff, 13'h0078};
   logic [12:0]  sy [4]       = '{13'h0408, 13'h01f4, 13'h000b, 13'h0000};
   logic [8:0]   ex [4]       = '{9'h043, 9'h043, 9'h1fc, 9'h00a};
   logic [8:0]   ey [4]       = '{9'h056, 9'h029, 9'h00a, 9'h00a};

   // Clock
   initial begin
      forever #5 clk = ~clk;
   end

   // Host gap shortened; the block does not time it
   tisc_host #(.GAP(20)) i_tisc_host (.clk(clk), .rx_data(rx_data), .rx_valid(rx_valid));

   tisc_top i_tisc_top (.CLK(clk), .RESET_N(reset_n), .RX_DATA(rx_data), .RX_VALID(rx_valid),
      .POS(pos), .POS_VALID(pos_valid), .BUTTON(button), .MODE(mode), .TRIGGER(trigger),
      .RATE_TICK(rate_tick), .RESTRICTED(restricted), .REPORT(report),
      .REPORT_VALID(report_valid), .REPORT_READY(report_ready), .THRESHOLD(threshold),
      .FILTER_ON(filter_on), .MET(met), .RES_X(res_x), .RES_Y(res_y));

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   task automatic tk;
      @(posedge clk);
      #1;
   endtask

   task automatic chk(input logic [32:0] got, input logic [32:0] exp, input string m);
      num_checks++;
      if (got !== exp) begin
         fails++;
         $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
      end
   endtask

   task automatic setpos(input logic [15:0] x, input logic [15:0] y);
      tk();
      pos       = '{x, y};
      pos_valid = 1'b1;
      tk();
      pos_valid = 1'b0;
   endtask

   task automatic pulse(input logic t, input logic r);
      tk();
      trigger   = t;
      rate_tick = r;
      tk();
      trigger   = 1'b0;
      rate_tick = 1'b0;
   endtask

   // Wait for a report, compare, then pop it
   task automatic exp_rep(input logic [15:0] x, input logic [15:0] y, input logic b);
      int n;
      n = 0;
      while (report_valid !== 1'b1 && n < 8) begin
         tk();
         n++;
      end
      chk(33'(report_valid), 33'h1, "report valid");
      chk(report, {x, y, b}, "report");
      report_ready = 1'b1;
      tk();
      report_ready = 1'b0;
   endtask

   task automatic no_rep;
      repeat (4) tk();
      chk(33'(report_valid), 33'h0, "no report");
   endtask

   task automatic fin(input string n);
      $display("test %s done", n);
   endtask

   task automatic report_and_stop;
      $display("checks %0d, mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // ------------------------------------------------------------
   // Tests
   // ------------------------------------------------------------
   initial begin
      pos          = '0;
      pos_valid    = 1'b0;
      button       = 1'b0;
      mode         = MODE_STREAM;
      trigger      = 1'b0;
      rate_tick    = 1'b0;
      restricted   = 1'b0;
      report_ready = 1'b0;
      repeat (6) @(posedge clk);
      #1;
      reset_n = 1'b1;
      chk(33'({res_x, res_y, threshold, filter_on, report_valid}), 33'({RES_200, RES_200, 9'h0}),
          "reset state");
      fin("reset");
      for (int i = 0; i < 7; i++) begin
         i_tisc_host.send(pcmd[i]);
         chk(33'({res_x, res_y}), 33'({pres[i], pres[i]}), "preset");
      end
      fin("presets");
      for (int i = 0; i < 4; i++) begin
         i_tisc_host.send_scale(sx[i], sy[i]);
         chk(33'({res_x, res_y}), 33'({ex[i], ey[i]}), "scale");
      end
      fin("scale");
      i_tisc_host.send_thr(7'h0a);
      chk(33'({threshold, filter_on}), 33'h15, "threshold 10");
      i_tisc_host.send(CMD_THRESH);
      i_tisc_host.send(8'h7b);
      chk(33'({threshold, filter_on}), 33'h15, "threshold kept");
      i_tisc_host.send_thr(7'h5a);
      chk(33'({threshold, filter_on}), 33'hb5, "threshold 90");
      i_tisc_host.send_thr(7'h00);
      chk(33'({threshold, filter_on}), 33'h0, "filter off");
      i_tisc_host.send_thr(7'h05);
      i_tisc_host.send(CMD_RESET);
      chk(33'({threshold, res_x, res_y}), 33'({7'h0, RES_200, RES_200}), "reset cmd");
      fin("threshold");
      setpos(16'h0064, 16'h0064);
      pulse(1'b0, 1'b1);
      exp_rep(16'h0064, 16'h0064, 1'b0);
      i_tisc_host.send_thr(7'h0a);
      setpos(16'h0069, 16'h0069);
      pulse(1'b0, 1'b1);
      no_rep();
      chk(33'(met), 33'h0, "met inside square");
      setpos(16'h006e, 16'h0067);
      pulse(1'b0, 1'b1);
      exp_rep(16'h006e, 16'h0067, 1'b0);
      fin("stream");
      mode = MODE_POLL;
      setpos(16'h0073, 16'h0067);
      pulse(1'b1, 1'b0);
      exp_rep(16'h006e, 16'h0067, 1'b0);
      setpos(16'h0073, 16'h0071);
      pulse(1'b1, 1'b0);
      exp_rep(16'h0073, 16'h0071, 1'b0);
      fin("poll");
      mode = MODE_EDGE;
      setpos(16'h0078, 16'h0071);
      button = 1'b1;
      exp_rep(16'h0073, 16'h0071, 1'b1);
      button = 1'b0;
      exp_rep(16'h0073, 16'h0071, 1'b0);
      fin("edge");
      mode = MODE_GATED;
      tk();
      button = 1'b1;
      exp_rep(16'h0073, 16'h0071, 1'b1);
      pulse(1'b0, 1'b1);
      no_rep();
      setpos(16'h007d, 16'h0071);
      pulse(1'b0, 1'b1);
      exp_rep(16'h007d, 16'h0071, 1'b1);
      button = 1'b0;
      exp_rep(16'h007d, 16'h0071, 1'b0);
      fin("gated");
      i_tisc_host.send_thr(7'h00);
      restricted = 1'b1;
      mode       = MODE_STREAM;
      setpos(16'h2000, 16'h0010);
      repeat (3) pulse(1'b0, 1'b1);
      exp_rep(16'h0fff, 16'h0010, 1'b0);
      exp_rep(16'h0fff, 16'h0010, 1'b0);
      no_rep();
      fin("buffer clamp");
      report_and_stop();
   end

   // Watchdog
   initial begin
      #100000;
      fails++;
      report_and_stop();
   end
endmodule
